// *** rtl/sbi_pkg.sv ***
// Shared constants and types of the servo brake interlock sequencer.
package sbi_pkg;

  // Time base: system clock period and the delay tick derived from it.
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Speed at or below which the motor counts as stopped, in r/min.
  localparam logic [15:0] STOPPED_RPM = 16'h001E;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STOP_DLY = 8'h04;
  localparam logic [7:0] OFS_RUN_DLY  = 8'h08;
  localparam logic [7:0] OFS_SPD_THR  = 8'h0C;
  localparam logic [7:0] OFS_CLR_TIME = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;

  // Control register fields.
  localparam int CTRL_W       = 7;
  localparam int CTRL_ON_BIT  = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_GPO_LSB = 4;

  // Values after reset; delays and the recognition time count 1 ms ticks.
  localparam logic [CTRL_W-1:0] CTRL_RST     = 7'h00;
  localparam logic [15:0]       STOP_DLY_RST = 16'h0064;
  localparam logic [15:0]       RUN_DLY_RST  = 16'h01F4;
  localparam logic [15:0]       SPD_THR_RST  = 16'h001E;
  localparam logic [15:0]       CLR_TIME_RST = 16'h0078;

  // Interrupt status bits.
  localparam int IRQ_W       = 4;
  localparam int IRQ_ON_BIT  = 0;
  localparam int IRQ_OFF_BIT = 1;
  localparam int IRQ_ALM_BIT = 2;
  localparam int IRQ_CLR_BIT = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_OFF  = 2'h0,
    ST_ON   = 2'h1,
    ST_STOP = 2'h3,
    ST_ALM  = 2'h2
  } sbi_state_e;

endpackage

// *** rtl/sbi_timer_if.sv ***
// Load, tick and done signals between the sequencer and one down-counter.
`timescale 1ns/1ps
interface sbi_timer_if #(parameter int W = 16);
  logic         load;
  logic [W-1:0] value;
  logic         tick;
  logic         done;
  modport ctl (output load, output value, output tick, input done);
  modport cnt (input load, input value, input tick, output done);
endinterface

// *** rtl/sbi_tick.sv ***
// Fixed time tick: one pulse every CYCLES clocks.
`timescale 1ns/1ps
module sbi_tick #(
  parameter int CYCLES = 10000
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Tick
  output logic      tickPulse
);
  localparam int CW = $clog2(CYCLES);

  if (CYCLES < 2) begin : g_bad_cycles
    $error("sbi_tick needs at least two cycles per tick");
  end

  logic [CW-1:0] count_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_r   <= '0;
      tickPulse <= 1'b0;
    end else if (count_r == CW'(CYCLES - 1)) begin
      count_r   <= '0;
      tickPulse <= 1'b1;
    end else begin
      count_r   <= count_r + 1'b1;
      tickPulse <= 1'b0;
    end
  end
endmodule

// *** rtl/sbi_down_counter.sv ***
// Down-counter reloaded on load and decremented once per tick.
`timescale 1ns/1ps
module sbi_down_counter (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Timer channel
  sbi_timer_if.cnt  tmr
);
  logic [$bits(tmr.value)-1:0] count_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else if (tmr.load) begin
      count_r <= tmr.value;
    end else if (tmr.tick && count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  // A load in progress hides a stale zero from the previous run.
  assign tmr.done = (count_r == '0) && !tmr.load;
endmodule

// *** rtl/sbi_sequencer.sv ***
// Servo enable and holding-brake interlock sequencer with AXI4-Lite registers.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - A servo OFF with the motor stopped waits the stopped brake delay, then drops brake release and motor power.
// - A servo OFF while rotating starts the running brake delay and drops brake release and power when it expires.
// - In a running stop, brake release drops early once speed is at or below the brake release speed threshold.
// - The running-stop brake interval is the shorter of the running delay and the time to reach the threshold.
// - Servo ON is never entered while the motor turns faster than about 30 r/min.
// - A servo ON request during deceleration after servo OFF or an alarm waits until the motor has stopped.
// - The dynamic brake behaviour at servo OFF follows the servo-off stop selection.
// - An alarm during servo ON applies the selected dynamic brake and releases the brake with the running-stop rule.
// - Brake release is asserted only on request of servo control and is routed to an assignable general output.
// - Main power loss while the motor runs raises an alarm that follows the alarm stop timing.
// - Alarm reset is accepted only after the input is held for the alarm clear time, 120 ms by default.
// - After an alarm reset the servo stays OFF until the host issues a fresh servo ON.
module sbi_sequencer
  import sbi_pkg::*;
#(
  parameter int ADDR_W   = 8,
  parameter int GPO_W    = 8,
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Drive status
  input  wire logic [15:0]       motorSpeed,
  input  wire logic              alarmIn,
  input  wire logic              mainPowerLost,
  // Drive control
  output logic                   brakeHoldReleaseOut,
  output logic                   motorExcite,
  output logic                   dynBrakeOn,
  output logic [GPO_W-1:0]       generalOutputConnector,
  output logic                   irq
);

  if (ADDR_W < 5 || GPO_W < 1 || GPO_W > 8) begin : g_bad_param
    $error("sbi_sequencer: ADDR_W must be at least 5 and GPO_W 1 to 8");
  end

  sbi_state_e        state_r;
  sbi_state_e        state_nxt;
  logic [CTRL_W-1:0] ctrl_r;
  logic [15:0]       stopDly_r;
  logic [15:0]       runDly_r;
  logic [15:0]       spdThr_r;
  logic [15:0]       clrTime_r;
  logic [IRQ_W-1:0]  irqStat_r;
  logic [IRQ_W-1:0]  irqStat_nxt;
  logic [IRQ_W-1:0]  irqMask_r;
  logic              runStop_r;
  logic              runStop_nxt;
  logic              onArmed_r;
  logic              alarmLat_r;
  logic              brake_nxt;
  logic              excite_nxt;
  logic              dynBrake_nxt;
  logic              brkLoad;
  logic [15:0]       brkValue;
  logic              tickPulse;

  sbi_timer_if #(.W(16)) brkTmr ();
  sbi_timer_if #(.W(16)) clrTmr ();

  sbi_tick #(.CYCLES(TICK_CYC)) u_tick (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .tickPulse (tickPulse)
  );

  sbi_down_counter u_brk_cnt (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tmr     (brkTmr)
  );

  sbi_down_counter u_clr_cnt (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tmr     (clrTmr)
  );

  wire logic       onReq     = ctrl_r[CTRL_ON_BIT];
  wire logic       resetReq  = ctrl_r[CTRL_RST_BIT];
  wire logic [1:0] stopSel   = ctrl_r[CTRL_SEL_LSB +: 2];
  wire logic [2:0] gpoSel    = ctrl_r[CTRL_GPO_LSB +: 3];
  wire logic       stopped   = motorSpeed <= STOPPED_RPM;
  wire logic       belowThr  = motorSpeed <= spdThr_r;
  // Power loss only counts as an alarm while the motor is still turning.
  wire logic       alarmEvt  = alarmIn || (mainPowerLost && !stopped);
  wire logic       timerLive = (state_r == ST_STOP) || (state_r == ST_ALM);
  wire logic       clrAccept = (state_r == ST_ALM) && resetReq && clrTmr.done && !alarmIn && !mainPowerLost;

  // Both timers run on the same tick and reload at their trigger.
  assign brkTmr.tick  = tickPulse;
  assign brkTmr.load  = brkLoad;
  assign brkTmr.value = brkValue;
  assign clrTmr.tick  = tickPulse;
  assign clrTmr.load  = !resetReq || (state_r != ST_ALM);
  assign clrTmr.value = clrTime_r;

  always_comb begin
    state_nxt   = state_r;
    brkLoad     = 1'b0;
    brkValue    = runDly_r;
    runStop_nxt = runStop_r;
    case (state_r)
      ST_OFF: begin
        if (alarmEvt) begin
          state_nxt = ST_ALM;
        end else if (onReq && onArmed_r && stopped) begin
          state_nxt = ST_ON;
        end
      end
      ST_ON: begin
        if (alarmEvt) begin
          state_nxt   = ST_ALM;
          brkLoad     = 1'b1;
          runStop_nxt = 1'b1;
        end else if (!onReq) begin
          state_nxt   = ST_STOP;
          brkLoad     = 1'b1;
          runStop_nxt = !stopped;
          brkValue    = stopped ? stopDly_r : runDly_r;
        end
      end
      ST_STOP: begin
        if (alarmEvt) begin
          state_nxt   = ST_ALM;
          runStop_nxt = 1'b1;
        end else if (brkTmr.done) begin
          state_nxt = ST_OFF;
        end
      end
      ST_ALM: begin
        if (clrAccept) begin
          state_nxt = ST_OFF;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  always_comb begin
    // Brake release is only held while servo control asks for it.
    brake_nxt = (state_nxt == ST_ON) ||
                ((state_nxt != ST_OFF) && brakeHoldReleaseOut &&
                 !(timerLive && brkTmr.done) && !(runStop_nxt && belowThr));
    // Power stays on through a servo-off delay, but an alarm cuts it at once.
    excite_nxt = (state_nxt == ST_ON) || (state_nxt == ST_STOP);
    // Stop selection: bit 0 governs deceleration, bit 1 the stopped motor.
    if ((state_nxt == ST_OFF) || (state_nxt == ST_ALM)) begin
      dynBrake_nxt = stopped ? !stopSel[1] : !stopSel[0];
    end else begin
      dynBrake_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r   <= ST_OFF;
      runStop_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      runStop_r <= runStop_nxt;
    end
  end

  // A fresh low-to-high servo ON is needed after every alarm.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      onArmed_r <= 1'b0;
    end else if (state_nxt == ST_ALM) begin
      onArmed_r <= 1'b0;
    end else if (!onReq) begin
      onArmed_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alarmLat_r <= 1'b0;
    end else if (alarmEvt) begin
      alarmLat_r <= 1'b1;
    end else if (clrAccept) begin
      alarmLat_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      brakeHoldReleaseOut <= 1'b0;
      motorExcite         <= 1'b0;
      dynBrakeOn          <= 1'b1;
    end else begin
      brakeHoldReleaseOut <= brake_nxt;
      motorExcite         <= excite_nxt;
      dynBrakeOn          <= dynBrake_nxt;
    end
  end

  // Brake release is mirrored on the general output picked by software.
  for (genvar g = 0; g < GPO_W; g++) begin : g_gpo
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        generalOutputConnector[g] <= 1'b0;
      end else begin
        generalOutputConnector[g] <= brake_nxt && (gpoSel == 3'(g));
      end
    end
  end

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] ws);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (ws[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  wire logic       wrHs  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic       rdHs  = s_axi_arvalid && s_axi_arready;
  wire logic [7:0] wAddr = 8'(s_axi_awaddr);
  wire logic [7:0] rAddr = 8'(s_axi_araddr);
  wire logic       wHigh = (s_axi_awaddr >> 8) != '0;
  wire logic       rHigh = (s_axi_araddr >> 8) != '0;

  // Address and data are taken together in one cycle, once both are offered.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wrHs) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (!wHigh && wAddr <= OFS_IRQ_MASK && wAddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r    <= CTRL_RST;
      stopDly_r <= STOP_DLY_RST;
      runDly_r  <= RUN_DLY_RST;
      spdThr_r  <= SPD_THR_RST;
      clrTime_r <= CLR_TIME_RST;
      irqMask_r <= IRQ_MASK_RST;
    end else if (wrHs && !wHigh) begin
      case (wAddr)
        OFS_CTRL:     ctrl_r    <= CTRL_W'(wmerge(32'(ctrl_r), s_axi_wdata, s_axi_wstrb));
        OFS_STOP_DLY: stopDly_r <= 16'(wmerge(32'(stopDly_r), s_axi_wdata, s_axi_wstrb));
        OFS_RUN_DLY:  runDly_r  <= 16'(wmerge(32'(runDly_r), s_axi_wdata, s_axi_wstrb));
        OFS_SPD_THR:  spdThr_r  <= 16'(wmerge(32'(spdThr_r), s_axi_wdata, s_axi_wstrb));
        OFS_CLR_TIME: clrTime_r <= 16'(wmerge(32'(clrTime_r), s_axi_wdata, s_axi_wstrb));
        OFS_IRQ_MASK: irqMask_r <= IRQ_W'(wmerge(32'(irqMask_r), s_axi_wdata, s_axi_wstrb));
        default: begin
        end
      endcase
    end
  end

  // A read of the status clears it, but an event in the same cycle survives.
  always_comb begin
    irqStat_nxt = irqStat_r;
    if (rdHs && !rHigh && rAddr == OFS_IRQ_STAT) begin
      irqStat_nxt = '0;
    end
    irqStat_nxt[IRQ_ON_BIT]  = irqStat_nxt[IRQ_ON_BIT] || (state_nxt == ST_ON && state_r != ST_ON);
    irqStat_nxt[IRQ_OFF_BIT] = irqStat_nxt[IRQ_OFF_BIT] || (state_r == ST_STOP && state_nxt == ST_OFF);
    irqStat_nxt[IRQ_ALM_BIT] = irqStat_nxt[IRQ_ALM_BIT] || (state_nxt == ST_ALM && state_r != ST_ALM);
    irqStat_nxt[IRQ_CLR_BIT] = irqStat_nxt[IRQ_CLR_BIT] || clrAccept;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqStat_r <= '0;
      irq       <= 1'b0;
    end else begin
      irqStat_r <= irqStat_nxt;
      irq       <= |(irqStat_nxt & irqMask_r);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rdHs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (rHigh ? 8'hFF : rAddr)
          OFS_CTRL:     s_axi_rdata <= 32'(ctrl_r);
          OFS_STOP_DLY: s_axi_rdata <= 32'(stopDly_r);
          OFS_RUN_DLY:  s_axi_rdata <= 32'(runDly_r);
          OFS_SPD_THR:  s_axi_rdata <= 32'(spdThr_r);
          OFS_CLR_TIME: s_axi_rdata <= 32'(clrTime_r);
          OFS_STATUS:   s_axi_rdata <= 32'({onArmed_r, alarmLat_r, dynBrakeOn, motorExcite,
                                            brakeHoldReleaseOut, state_r});
          OFS_IRQ_STAT: s_axi_rdata <= 32'(irqStat_r);
          OFS_IRQ_MASK: s_axi_rdata <= 32'(irqMask_r);
          default:      s_axi_rresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  a_on_when_slow: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r != ST_ON) ##1 (state_r == ST_ON) |-> $past(stopped) && $past(onArmed_r))
    else $error("servo ON entered while motor turning or not armed");

  a_stop_expiry: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_STOP) && brkTmr.done && !alarmEvt |=> (state_r == ST_OFF) && !motorExcite && !brakeHoldReleaseOut)
    else $error("servo-off delay expiry did not drop brake and power");

  a_run_early: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_STOP) && runStop_r && belowThr |=> !brakeHoldReleaseOut)
    else $error("running stop kept brake released below threshold");

  a_stopped_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_ON) && !onReq && !alarmEvt && stopped && (stopDly_r != 16'h0000)
    |=> (state_r == ST_STOP) && brakeHoldReleaseOut && motorExcite)
    else $error("stopped servo-off did not hold brake release for the delay");

  a_alarm_entry: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_ON) && alarmEvt |=> (state_r == ST_ALM) && !motorExcite && runStop_r)
    else $error("alarm during servo ON not handled with alarm stop timing");

  a_t1_release: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_ALM) && (brkTmr.done || belowThr) |=> !brakeHoldReleaseOut)
    else $error("brake release outlived the t1 interval");

  a_brake_on_req: assert property (@(posedge sys_clk) disable iff (rst)
    brakeHoldReleaseOut |-> (state_r != ST_OFF) &&
      (generalOutputConnector[$past(gpoSel)] || 4'($past(gpoSel)) >= 4'(GPO_W)))
    else $error("brake release without servo request or not routed");

  a_clear_held: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_ALM) ##1 (state_r == ST_OFF) |-> $past(resetReq) && $past(clrTmr.done))
    else $error("alarm cleared before reset input was held long enough");

  a_fresh_on: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_ALM) && onReq ##1 (state_r == ST_OFF) && onReq |=> (state_r != ST_ON))
    else $error("servo re-enabled after alarm reset without fresh servo ON");

  a_db_select: assert property (@(posedge sys_clk) disable iff (rst)
    (state_nxt == ST_OFF) && !stopped |=> dynBrakeOn == !$past(stopSel[0]))
    else $error("dynamic brake does not follow stop selection");

endmodule

// *** bench/sbi_motor_model.sv ***
// Behavioural motor that follows its setpoint while excited and coasts down when not.
`timescale 1ns/1ps
module sbi_motor_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Drive side
  input  wire logic        motorExcite,
  input  wire logic [15:0] setpoint,
  input  wire logic        loadSpin,
  // Sensed speed
  output logic      [15:0] motorSpeed
);
  logic [15:0] target;

  // An overhauling load may keep the shaft turning, so the bench can hold the speed up.
  assign target = motorExcite ? setpoint : 16'h0000;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      motorSpeed <= 16'h0000;
    end else if (!loadSpin) begin
      if (motorSpeed + 16'h0002 <= target) begin
        motorSpeed <= motorSpeed + 16'h0002;
      end else if (motorSpeed > target + 16'h0002) begin
        motorSpeed <= motorSpeed - 16'h0002;
      end else begin
        motorSpeed <= target;
      end
    end
  end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the servo brake interlock sequencer.
`timescale 1ns/1ps
module tb;
  import sbi_pkg::*;
  logic        sys_clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [15:0] motorSpeed;
  logic [15:0] setpoint = 16'h0000;
  logic        loadSpin = 1'h0;
  logic        mainPowerLost = 1'h0;
  logic        alarmIn = 1'h0;
  logic        brakeHoldReleaseOut, motorExcite, dynBrakeOn;
  logic [7:0]  gpo;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cyc = 0;
  int          w;

  always #50 sys_clk = ~sys_clk;

  // A 4-cycle tick keeps every millisecond delay short in simulation.
  sbi_sequencer #(.TICK_CYC(4)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .motorSpeed(motorSpeed), .alarmIn(alarmIn), .mainPowerLost(mainPowerLost),
    .brakeHoldReleaseOut(brakeHoldReleaseOut), .motorExcite(motorExcite), .dynBrakeOn(dynBrakeOn),
    .generalOutputConnector(gpo), .irq(irq));

  sbi_motor_model i_motor (.sys_clk(sys_clk), .rst(rst), .motorExcite(motorExcite),
    .setpoint(setpoint), .loadSpin(loadSpin), .motorSpeed(motorSpeed));

  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chkw(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string m);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %b expected %b", $time, m, got, exp);
    end
  endtask

  // Every bus task ends one edge after its answer, so a following request never collides.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic waitv(ref logic s, input logic v, input int lim);
    w = 0;
    while (s !== v && w < lim) begin
      @(posedge sys_clk);
      w++;
    end
    chkb(s, v, "level not reached in time");
  endtask

  function automatic logic [31:0] cv(logic on, logic clr, logic [1:0] sel);
    return 32'(on) | (32'(clr) << CTRL_RST_BIT) | (32'(sel) << CTRL_SEL_LSB) | (32'h2 << CTRL_GPO_LSB);
  endfunction

  task automatic t_regs();
    chkb(dynBrakeOn, 1'h1, "dyn brake after reset");
    rdr(OFS_STOP_DLY);
    chkw(rd, {16'h0, STOP_DLY_RST}, "stop delay reset");
    rdr(OFS_RUN_DLY);
    chkw(rd, {16'h0, RUN_DLY_RST}, "run delay reset");
    rdr(OFS_CLR_TIME);
    chkw(rd, {16'h0, CLR_TIME_RST}, "clear time reset");
    rdr(8'h20);
    chkw(32'(rsp), 32'(RESP_SLVERR), "unmapped read");
    wr(OFS_STOP_DLY, 32'h3);
    wr(OFS_RUN_DLY, 32'h5);
    wr(OFS_CLR_TIME, 32'h3);
    wr(OFS_IRQ_MASK, 32'h2);
    chkw(32'(rsp), 32'(RESP_OKAY), "write response");
  endtask

  task automatic t_stopped();
    wr(OFS_CTRL, cv(1'h1, 1'h0, 2'h2));
    waitv(motorExcite, 1'h1, 10);
    chkb(brakeHoldReleaseOut, 1'h1, "brake released in on");
    chkb(gpo[2], 1'h1, "output mirrors brake");
    wr(OFS_CTRL, cv(1'h0, 1'h0, 2'h2));
    repeat (6) @(posedge sys_clk);
    chkb(brakeHoldReleaseOut, 1'h1, "brake held early");
    waitv(brakeHoldReleaseOut, 1'h0, 14);
    chkb(motorExcite, 1'h0, "power off with brake");
    repeat (2) @(posedge sys_clk);
    chkb(dynBrakeOn, 1'h0, "stopped select off");
    chkb(irq, 1'h1, "stop irq");
    rdr(OFS_IRQ_STAT);
    chkb(rd[IRQ_OFF_BIT], 1'h1, "stop flagged");
    wr(OFS_CTRL, cv(1'h0, 1'h0, 2'h0));
    chkb(irq, 1'h0, "irq cleared by read");
    chkb(dynBrakeOn, 1'h1, "stopped select on");
  endtask

  task automatic t_run_hold();
    setpoint <= 16'h00C8;
    wr(OFS_CTRL, cv(1'h1, 1'h0, 2'h1));
    repeat (110) @(posedge sys_clk);
    loadSpin <= 1'h1;
    wr(OFS_CTRL, cv(1'h0, 1'h0, 2'h1));
    waitv(motorExcite, 1'h0, 40);
    chkb(w >= 16, 1'h1, "run delay honoured");
    chkb(brakeHoldReleaseOut, 1'h0, "brake off at run delay");
    wr(OFS_CTRL, cv(1'h1, 1'h0, 2'h1));
    chkb(dynBrakeOn, 1'h0, "running select off");
    repeat (20) @(posedge sys_clk);
    chkb(motorExcite, 1'h0, "no servo on while turning");
    setpoint <= 16'h0000;
    loadSpin <= 1'h0;
    waitv(motorExcite, 1'h1, 120);
    chkb(motorSpeed <= 16'h001E, 1'h1, "on only once stopped");
  endtask

  task automatic t_run_decel();
    wr(OFS_RUN_DLY, 32'h32);
    setpoint <= 16'h00C8;
    repeat (110) @(posedge sys_clk);
    setpoint <= 16'h0000;
    wr(OFS_CTRL, cv(1'h0, 1'h0, 2'h1));
    waitv(brakeHoldReleaseOut, 1'h0, 150);
    chkb(motorSpeed <= 16'h001E && motorSpeed > 16'h0010, 1'h1, "brake at threshold");
    chkb(motorExcite, 1'h1, "power kept until delay");
    waitv(motorExcite, 1'h0, 220);
  endtask

  task automatic t_alarm();
    wr(OFS_CTRL, cv(1'h1, 1'h0, 2'h1));
    setpoint <= 16'h00C8;
    repeat (110) @(posedge sys_clk);
    mainPowerLost <= 1'h1;
    waitv(motorExcite, 1'h0, 4);
    @(posedge sys_clk);
    chkb(dynBrakeOn, 1'h0, "alarm running select");
    chkb(brakeHoldReleaseOut, 1'h1, "brake held while fast");
    waitv(brakeHoldReleaseOut, 1'h0, 150);
    chkb(motorSpeed <= 16'h001E, 1'h1, "alarm brake at threshold");
    mainPowerLost <= 1'h0;
    setpoint <= 16'h0000;
    waitv(dynBrakeOn, 1'h1, 40);
    rdr(OFS_STATUS);
    chkw(32'(rd[1:0]), 32'(ST_ALM), "alarm state");
    wr(OFS_CTRL, cv(1'h0, 1'h1, 2'h1));
    wr(OFS_CTRL, cv(1'h0, 1'h0, 2'h1));
    rdr(OFS_STATUS);
    chkw(32'(rd[1:0]), 32'(ST_ALM), "short reset refused");
    wr(OFS_CTRL, cv(1'h1, 1'h1, 2'h1));
    repeat (16) @(posedge sys_clk);
    wr(OFS_CTRL, cv(1'h1, 1'h0, 2'h1));
    rdr(OFS_STATUS);
    chkw(32'(rd[1:0]), 32'(ST_OFF), "reset accepted");
    chkb(motorExcite, 1'h0, "held servo ON needs a fresh edge");
    wr(OFS_CTRL, cv(1'h0, 1'h0, 2'h1));
    wr(OFS_CTRL, cv(1'h1, 1'h0, 2'h1));
    waitv(motorExcite, 1'h1, 10);
    alarmIn <= 1'h1;
    waitv(motorExcite, 1'h0, 4);
    alarmIn <= 1'h0;
    chkb(brakeHoldReleaseOut, 1'h0, "stopped alarm brakes at once");
    chkb(dynBrakeOn, 1'h1, "alarm stopped select");
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    t_regs();
    t_stopped();
    t_run_hold();
    t_run_decel();
    t_alarm();
    summarize();
  end

  // The scenarios need about one thousand cycles; the run limit of 20000 cycles lies twenty times above that.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("[FAIL] %0t run limit reached", $time);
      summarize();
    end
  end
endmodule
